// >>> hw/acr_regs.svh
// Offsets, field positions, select codes and reset values of the input configuration bank
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ----------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------
`define ACR_WORD_W          16
`define ACR_SEL_HI          15
`define ACR_SEL_LO          11
`define ACR_FIELD_HI        10
`define ACR_FIELD_LO        3
`define ACR_CFG_FLAG_BIT    15
`define ACR_COMMON_REF_BIT  2
`define ACR_LAST_BIT_IDX    4'hF

// ----------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------
`define ACR_PAIR_UNIPOLAR_SELECT_CODE  5'h11
`define ACR_PAIR_BIPOLAR_SELECT_CODE   5'h12
`define ACR_UPPER_SCAN_SELECT_CODE     5'h14
`define ACR_LOWER_SCAN_SELECT_CODE     5'h15

// ----------------------------------------------------------------
// Reset values and masks of the stored images
// ----------------------------------------------------------------
`define ACR_PAIR_UNIPOLAR_RESET  16'h0000
`define ACR_PAIR_BIPOLAR_RESET   16'h0000
`define ACR_UPPER_SCAN_RESET     16'h0000
`define ACR_LOWER_SCAN_RESET     16'h0000
`define ACR_UNIPOLAR_KEEP_MASK   16'h07FC
`define ACR_FIELD_KEEP_MASK      16'h07F8
`define ACR_SHARED_COMMON_INPUT  4'hF

`endif

// >>> hw/acr_pkg.sv
// Types shared by the input configuration bank
package acr_pkg;

    // ----------------------------------------------------------------
    // Serial configuration word
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0] sel;
        logic [7:0] field;
        logic [2:0] low;
    } acr_word_t;

    // ----------------------------------------------------------------
    // Scan modes, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [7:0] {
        ACR_SCAN_MANUAL     = 8'h01,
        ACR_SCAN_REPEAT     = 8'h02,
        ACR_SCAN_STD_INT    = 8'h04,
        ACR_SCAN_STD_EXT    = 8'h08,
        ACR_SCAN_UPPER_INT  = 8'h10,
        ACR_SCAN_UPPER_EXT  = 8'h20,
        ACR_SCAN_CUSTOM_INT = 8'h40,
        ACR_SCAN_CUSTOM_SCAN_EXTERNAL_CLOCK_MODE = 8'h80
    } acr_scan_mode_t;

    // ----------------------------------------------------------------
    // Resolved conversion
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ACR_CONV_SINGLE   = 4'h1,
        ACR_CONV_PAIR_UNI = 4'h2,
        ACR_CONV_PAIR_BIP = 4'h4,
        ACR_CONV_COMMON   = 4'h8
    } acr_conv_t;

    typedef struct packed {
        acr_conv_t  conv;
        logic       twosComplement;
        logic [3:0] posInput;
        logic [3:0] negInput;
    } acr_resolve_t;

    // ----------------------------------------------------------------
    // Serial receiver states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ACR_RX_IDLE  = 3'h1,
        ACR_RX_SHIFT = 3'h2,
        ACR_RX_WAIT  = 3'h4
    } acr_rx_state_t;

endpackage

// >>> hw/acr_input_config.sv
// Input configuration register bank: serial write path, stored images and channel resolve
//
// Summary of operation
// - Word with select 10001 in bits 15:11 loads the pair-unipolar register.
// - Word with select 10010 in bits 15:11 loads the pair-bipolar register.
// - Word with select 10100 loads the upper scan enables, inputs 8 to 15.
// - Word with select 10101 loads the lower scan enables, inputs 0 to 7.
// - Unipolar bits 10..3 pick pseudo-differential per pair, pair 0/1 first; reset zero.
// - Unipolar, bipolar and common flag all clear give single-ended conversion.
// - Unipolar bit 2 refers inputs 0 to 14 to input 15; reset zero.
// - Bipolar bits 10..3 pick fully differential per pair, pair 0/1 first; reset zero.
// - Upper scan bits 10..3 enable inputs 15 down to 8; reset zero.
// - Lower scan bits 10..3 enable inputs 7 down to 0; reset zero.
// - Bipolar only, common clear: pair converted differentially, two's complement.
// - Unipolar only, common clear: pair converted, straight binary.
// - Unipolar and bipolar both set: unipolar wins, straight binary.
// - Common flag set: input against shared input 15, binary, pair bits ignored.
// - The same decode applies to every even/odd pair.
// - Channel field selects in non-custom modes; scan enables only in custom modes.
// - Config during conversion: data marked invalid until a mode-control word.
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs.svh"

module acr_input_config (
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Serial pins
    input  wire logic                 sclk,
    input  wire logic                 csN,
    input  wire logic                 din,
    // Scan control and conversion engine
    input  wire acr_pkg::acr_scan_mode_t scanMode,
    input  wire logic [3:0]           channelSelectField,
    input  wire logic                 convBusy,
    // Stored register images
    output logic [15:0]               pairUnipolarConfig,
    output logic [15:0]               pairBipolarConfig,
    output logic [15:0]               upperScanEnable,
    output logic [15:0]               lowerScanEnable,
    // Resolved setup
    output acr_pkg::acr_resolve_t     resolved,
    output logic [15:0]               channelMask,
    output logic                      commonReferenceFlag,
    output logic                      dataInvalid,
    output logic                      modeWordStb
);
    import acr_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Pair p of a stored image sits at bit 10-p
    function automatic logic pairBit(input logic [15:0] img, input logic [3:0] ch);
        logic [2:0] p;
        p = ch[3:1];
        pairBit = img[`ACR_FIELD_HI - 32'(p)];
    endfunction

    // Keeping only live field bits makes unused positions read as zero
    function automatic logic [15:0] fieldImage(input acr_word_t w, input logic [15:0] keep);
        fieldImage = w & keep;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops per pin keep a metastable level away from the receiver
    // Limitation: each sclk phase must span at least one clk rising edge or a bit is lost
    logic [2:0] syncA_q;
    logic [2:0] syncB_q;
    logic       sclkLast_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            syncA_q    <= 3'h7;
            syncB_q    <= 3'h7;
            sclkLast_q <= 1'b1;
        end else if (ce) begin
            syncA_q    <= {sclk, csN, din};
            syncB_q    <= syncA_q;
            sclkLast_q <= syncB_q[2];
        end
    end

    logic sclkS;
    logic csNS;
    logic dinS;
    logic sclkRise;

    assign sclkS    = syncB_q[2];
    assign csNS     = syncB_q[1];
    assign dinS     = syncB_q[0];
    assign sclkRise = sclkS && !sclkLast_q;

    // ----------------------------------------------------------------
    // Serial receiver
    // ----------------------------------------------------------------
    acr_rx_state_t state_q;
    acr_rx_state_t state_d;
    logic [15:0]   shift_q;
    logic [15:0]   shift_d;
    logic [3:0]    count_q;
    logic [3:0]    count_d;
    logic          wordDone;

    // Bits beyond sixteen in one frame are ignored until the frame ends
    // A frame cut before sixteen bits never raises wordDone, so nothing is written
    always_comb begin
        state_d  = state_q;
        shift_d  = shift_q;
        count_d  = count_q;
        wordDone = 1'b0;
        unique case (state_q)
            ACR_RX_IDLE: begin
                // Bit count restarts at every frame start
                count_d = 4'h0;
                if (!csNS) begin
                    state_d = ACR_RX_SHIFT;
                end
            end
            ACR_RX_SHIFT: begin
                if (csNS) begin
                    state_d = ACR_RX_IDLE;
                end else if (sclkRise) begin
                    shift_d = {shift_q[14:0], dinS};
                    count_d = count_q + 4'h1;
                    if (count_q == `ACR_LAST_BIT_IDX) begin
                        wordDone = 1'b1;
                        state_d  = ACR_RX_WAIT;
                    end
                end
            end
            ACR_RX_WAIT: begin
                // Surplus bits are dropped here until chip select rises
                if (csNS) begin
                    state_d = ACR_RX_IDLE;
                end
            end
            default: begin
                state_d = ACR_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ACR_RX_IDLE;
            shift_q <= 16'h0000;
            count_q <= 4'h0;
        end else if (ce) begin
            state_q <= state_d;
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    // ----------------------------------------------------------------
    // Register bank write decode
    // ----------------------------------------------------------------
    acr_word_t   word;
    logic [15:0] uni_q;
    logic [15:0] uni_d;
    logic [15:0] bip_q;
    logic [15:0] bip_d;
    logic [15:0] upper_q;
    logic [15:0] upper_d;
    logic [15:0] lower_q;
    logic [15:0] lower_d;
    logic        invalid_q;
    logic        invalid_d;
    logic        modeStb_q;
    logic        modeStb_d;

    // The sixteenth bit comes straight from the synchroniser to save a cycle
    assign word = acr_word_t'({shift_q[14:0], dinS});

    // Config during a conversion spoils later data until a mode word arrives
    always_comb begin
        uni_d     = uni_q;
        bip_d     = bip_q;
        upper_d   = upper_q;
        lower_d   = lower_q;
        invalid_d = invalid_q;
        modeStb_d = 1'b0;
        if (wordDone) begin
            if (!word.sel[4]) begin
                // Mode-control word revalidates the data path
                invalid_d = 1'b0;
                modeStb_d = 1'b1;
            end else begin
                if (convBusy) begin
                    invalid_d = 1'b1;
                end
                unique case (word.sel)
                    `ACR_PAIR_UNIPOLAR_SELECT_CODE:
                        uni_d = fieldImage(word, `ACR_UNIPOLAR_KEEP_MASK);
                    `ACR_PAIR_BIPOLAR_SELECT_CODE:
                        bip_d = fieldImage(word, `ACR_FIELD_KEEP_MASK);
                    `ACR_UPPER_SCAN_SELECT_CODE:
                        upper_d = fieldImage(word, `ACR_FIELD_KEEP_MASK);
                    `ACR_LOWER_SCAN_SELECT_CODE:
                        lower_d = fieldImage(word, `ACR_FIELD_KEEP_MASK);
                    default: begin
                        // Other codes belong to neighbouring registers
                        uni_d = uni_q;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            uni_q     <= `ACR_PAIR_UNIPOLAR_RESET;
            bip_q     <= `ACR_PAIR_BIPOLAR_RESET;
            upper_q   <= `ACR_UPPER_SCAN_RESET;
            lower_q   <= `ACR_LOWER_SCAN_RESET;
            invalid_q <= 1'b0;
            modeStb_q <= 1'b0;
        end else if (ce) begin
            uni_q     <= uni_d;
            bip_q     <= bip_d;
            upper_q   <= upper_d;
            lower_q   <= lower_d;
            invalid_q <= invalid_d;
            modeStb_q <= modeStb_d;
        end
    end

    // ----------------------------------------------------------------
    // Channel resolve
    // ----------------------------------------------------------------
    // Registered one cycle behind the images so every output is a flop
    acr_resolve_t res_q;
    acr_resolve_t res_d;
    logic [15:0]  mask_q;
    logic [15:0]  mask_d;
    logic         custom;

    // Scan enables matter only in the two custom scan modes
    assign custom = (scanMode == ACR_SCAN_CUSTOM_INT) || (scanMode == ACR_SCAN_CUSTOM_SCAN_EXTERNAL_CLOCK_MODE);

    // Priority: common flag, then unipolar, then bipolar, else single-ended
    always_comb begin
        res_d.posInput = channelSelectField;
        res_d.negInput = 4'h0;
        res_d.twosComplement = 1'b0;
        res_d.conv = ACR_CONV_SINGLE;
        if (uni_q[`ACR_COMMON_REF_BIT]) begin
            res_d.conv     = ACR_CONV_COMMON;
            res_d.negInput = `ACR_SHARED_COMMON_INPUT;
        end else if (pairBit(uni_q, channelSelectField)) begin
            // Unipolar takes precedence over bipolar
            res_d.conv     = ACR_CONV_PAIR_UNI;
            res_d.posInput = {channelSelectField[3:1], 1'b0};
            res_d.negInput = {channelSelectField[3:1], 1'b1};
        end else if (pairBit(bip_q, channelSelectField)) begin
            res_d.conv           = ACR_CONV_PAIR_BIP;
            res_d.twosComplement = 1'b1;
            res_d.posInput       = {channelSelectField[3:1], 1'b0};
            res_d.negInput       = {channelSelectField[3:1], 1'b1};
        end
        if (custom) begin
            // Input 15 at field bit 7 of the upper image
            mask_d = {upper_q[`ACR_FIELD_HI:`ACR_FIELD_LO],
                      lower_q[`ACR_FIELD_HI:`ACR_FIELD_LO]};
        end else begin
            mask_d = 16'h0001 << channelSelectField;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            res_q  <= '{conv: ACR_CONV_SINGLE, twosComplement: 1'b0,
                        posInput: 4'h0, negInput: 4'h0};
            mask_q <= 16'h0001;
        end else if (ce) begin
            res_q  <= res_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pairUnipolarConfig  = uni_q;
    assign pairBipolarConfig   = bip_q;
    assign upperScanEnable     = upper_q;
    assign lowerScanEnable     = lower_q;
    assign resolved            = res_q;
    assign channelMask         = mask_q;
    // The flag mirrors the stored bit, a cycle ahead of the resolved setup
    assign commonReferenceFlag = uni_q[`ACR_COMMON_REF_BIT];
    assign dataInvalid         = invalid_q;
    assign modeWordStb         = modeStb_q;

endmodule // acr_input_config

`default_nettype wire

// >>> dv/acr_input_config_properties.sv
// Concurrent checks on the ports of the input configuration bank
`timescale 1ns/1ps
`default_nettype none
module acr_input_config_properties (
    // Clock, reset, enable
    input wire logic                    clk,
    input wire logic                    rst,
    input wire logic                    ce,
    // Serial frame and scan control
    input wire logic                    csN,
    input wire acr_pkg::acr_scan_mode_t scanMode,
    input wire logic [3:0]              channelSelectField,
    // Watched outputs
    input wire logic [15:0]             pairUnipolarConfig,
    input wire logic [15:0]             pairBipolarConfig,
    input wire logic [15:0]             upperScanEnable,
    input wire logic [15:0]             lowerScanEnable,
    input wire acr_pkg::acr_resolve_t   resolved,
    input wire logic [15:0]             channelMask,
    input wire logic                    commonReferenceFlag,
    input wire logic                    dataInvalid,
    input wire logic                    modeWordStb
);
    import acr_pkg::*;
    // ----------------------------------------------------------------
    // Inputs of the resolve path, one cycle old
    // ----------------------------------------------------------------
    logic [3:0]  chQ;
    logic        uQ, bQ, cQ, okQ, custQ;
    logic [15:0] scanQ;
    logic [63:0] imgQ;
    always_ff @(posedge clk) begin
        chQ   <= channelSelectField;
        uQ    <= pairUnipolarConfig[4'hA - {1'b0, channelSelectField[3:1]}];
        bQ    <= pairBipolarConfig[4'hA - {1'b0, channelSelectField[3:1]}];
        cQ    <= pairUnipolarConfig[2];
        okQ   <= ce && !rst;
        custQ <= scanMode[7] | scanMode[6];
        scanQ <= {upperScanEnable[10:3], lowerScanEnable[10:3]};
        imgQ  <= {pairUnipolarConfig, pairBipolarConfig, upperScanEnable, lowerScanEnable};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_stb;
        modeWordStb ##1 !modeWordStb;
    endsequence
    property p_single;
        okQ && !cQ && !uQ && !bQ |-> resolved == {ACR_CONV_SINGLE, 1'b0, chQ, 4'h0};
    endproperty
    property p_pairUni;
        okQ && !cQ && uQ |->
            resolved == {ACR_CONV_PAIR_UNI, 1'b0, chQ[3:1], 1'b0, chQ[3:1], 1'b1};
    endproperty
    property p_pairBip;
        okQ && !cQ && !uQ && bQ |->
            resolved == {ACR_CONV_PAIR_BIP, 1'b1, chQ[3:1], 1'b0, chQ[3:1], 1'b1};
    endproperty
    property p_common;
        okQ && cQ && chQ != 4'hF |-> resolved == {ACR_CONV_COMMON, 1'b0, chQ, 4'hF};
    endproperty
    property p_flag;
        commonReferenceFlag == pairUnipolarConfig[2] &&
        (!okQ || (resolved.conv == ACR_CONV_COMMON) == cQ);
    endproperty
    property p_mask;
        okQ |-> channelMask == (custQ ? scanQ : 16'h0001 << chQ);
    endproperty
    property p_unused;
        (pairUnipolarConfig & 16'hF803) == 16'h0000 &&
        ((pairBipolarConfig | upperScanEnable | lowerScanEnable) & 16'hF807) == 16'h0000;
    endproperty
    // Images only move at the end of a frame that was still open three cycles earlier
    property p_write;
        okQ && imgQ != {pairUnipolarConfig, pairBipolarConfig, upperScanEnable,
                        lowerScanEnable} |-> $past(csN, 3) == 1'b0;
    endproperty
    property p_stbPulse;
        modeWordStb |-> s_stb;
    endproperty
    property p_invalid;
        modeWordStb |-> !dataInvalid;
    endproperty
    a_single:   assert property (p_single)   else $error("single-ended decode wrong");
    a_pairUni:  assert property (p_pairUni)  else $error("unipolar pair decode wrong");
    a_pairBip:  assert property (p_pairBip)  else $error("bipolar pair decode wrong");
    a_common:   assert property (p_common)   else $error("common input decode wrong");
    a_flag:     assert property (p_flag)     else $error("common flag output wrong");
    a_mask:     assert property (p_mask)     else $error("channel mask wrong");
    a_unused:   assert property (p_unused)   else $error("unused bits not zero");
    a_write:    assert property (p_write)    else $error("image moved outside a frame");
    a_stbPulse: assert property (p_stbPulse) else $error("mode strobe too long");
    a_invalid:  assert property (p_invalid)  else $error("invalid flag kept on mode word");
endmodule // acr_input_config_properties
bind acr_input_config acr_input_config_properties i_props (.*);
`default_nettype wire

// >>> dv/acr_host_model.sv
// Serial host that frames 16-bit words onto the configuration pins
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output var logic  sclk,
    output var logic  csN,
    output var logic  din
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        din  = 1'b0;
    end
    // ----------------------------------------------------------------
    // One frame; fewer than 16 bits aborts it, half sets the pace
    // ----------------------------------------------------------------
    task automatic send(input logic [15:0] word, input int nBits, input int half);
        int i;
        repeat (half) @(negedge clk);
        csN = 1'b0;
        repeat (half) @(negedge clk);
        for (i = 15; i > 15 - nBits; i--) begin
            din = word[i];
            repeat (half) @(negedge clk);
            sclk = 1'b1;
            repeat (half) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        csN = 1'b1;
        // Released line must not keep looking valid
        din = ~din;
    endtask
endmodule // acr_host_model
`default_nettype wire

// >>> dv/acr_input_config_tb.sv
// Self-checking bench of the input configuration bank
`timescale 1ns/1ps
`default_nettype none
module acr_input_config_tb;
    import acr_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           convBusy = 1'b0;
    logic           ce = 1'b1;
    acr_scan_mode_t scanMode = ACR_SCAN_MANUAL;
    logic [3:0]     chSel = 4'h0;
    wire            sclk, csN, din;
    logic [15:0]    pu, pb, us, ls, mask;
    acr_resolve_t   res;
    logic           cref, dInv, stb;
    int             fails = 0;
    int             totalChecks = 0;
    int             stbSeen = 0;
    int             cycles = 0;
    int             i;
    // Word sent, then expected unipolar, bipolar, upper and lower images
    localparam logic [79:0] ROWS [7] = '{
        80'h8FFF_07FC_0000_0000_0000, 80'h97FF_07FC_07F8_0000_0000,
        80'hA5A8_07FC_07F8_05A8_0000, 80'hAC3F_07FC_07F8_05A8_0438,
        80'hB7FF_07FC_07F8_05A8_0438, 80'h8800_0000_07F8_05A8_0438,
        80'h8C04_0404_07F8_05A8_0438};
    always #2.5 clk = ~clk;
    acr_host_model i_host (.clk(clk), .sclk(sclk), .csN(csN), .din(din));
    acr_input_config i_dut (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .csN(csN),
        .din(din), .scanMode(scanMode), .channelSelectField(chSel), .convBusy(convBusy),
        .pairUnipolarConfig(pu), .pairBipolarConfig(pb), .upperScanEnable(us),
        .lowerScanEnable(ls), .resolved(res), .channelMask(mask),
        .commonReferenceFlag(cref), .dataInvalid(dInv), .modeWordStb(stb));
    // ----------------------------------------------------------------
    // Compare, report, watchdog
    // ----------------------------------------------------------------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Mode strobe is counted on the falling edge, clear of its launching edge
    always @(negedge clk) begin
        if (stb === 1'b1) begin
            stbSeen++;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(pu | pb | us | ls, 17'h0);
        chk(res, {ACR_CONV_SINGLE, 1'b0, 4'h0, 4'h0});
        for (i = 0; i < 7; i++) begin
            i_host.send(ROWS[i][79:64], 16, 3 + (i % 2) * 3);
            chk(pu, ROWS[i][63:48]);
            chk(pb, ROWS[i][47:32]);
            chk(us, ROWS[i][31:16]);
            chk(ls, ROWS[i][15:0]);
        end
        chk(cref, 17'h1);
        for (i = 0; i < 15; i++) begin
            chSel = 4'(i);
            @(negedge clk);
            chk(res, {ACR_CONV_COMMON, 1'b0, 4'(i), 4'hF});
        end
        // Common flag off, pair 0/1 holds both pair bits
        i_host.send(16'h8C00, 16, 3);
        chSel = 4'h1;
        @(negedge clk);
        chk(res, {ACR_CONV_PAIR_UNI, 1'b0, 4'h0, 4'h1});
        chSel = 4'hE;
        @(negedge clk);
        chk(res, {ACR_CONV_PAIR_BIP, 1'b1, 4'hE, 4'hF});
        // Frame cut short after ten bits must not write
        i_host.send(16'h9000, 10, 3);
        chk(pb, 17'h07F8);
        i_host.send(16'h9000, 16, 3);
        chSel = 4'h1;
        @(negedge clk);
        chk(res, {ACR_CONV_PAIR_UNI, 1'b0, 4'h0, 4'h1});
        chSel = 4'h2;
        @(negedge clk);
        chk(res, {ACR_CONV_SINGLE, 1'b0, 4'h2, 4'h0});
        scanMode = ACR_SCAN_CUSTOM_SCAN_EXTERNAL_CLOCK_MODE;
        @(negedge clk);
        chk(mask, 17'hB587);
        scanMode = ACR_SCAN_UPPER_INT;
        @(negedge clk);
        chk(mask, 17'h0004);
        scanMode = ACR_SCAN_CUSTOM_INT;
        @(negedge clk);
        chk(mask, 17'hB587);
        convBusy = 1'b1;
        i_host.send(16'hA000, 16, 3);
        chk(dInv, 17'h1);
        convBusy = 1'b0;
        chk(17'(stbSeen), 17'h0);
        i_host.send(16'h0000, 16, 6);
        chk(dInv, 17'h0);
        chk(17'(stbSeen), 17'h1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(pu | pb | us | ls, 17'h0);
        // A frame sent while the clock enable is low must leave no trace
        ce = 1'b0;
        i_host.send(16'hA7F8, 16, 3);
        chk(us, 17'h0);
        ce = 1'b1;
        i_host.send(16'hA7F8, 16, 3);
        chk(us, 17'h07F8);
        close_out();
    end
endmodule // acr_input_config_tb
`default_nettype wire
